// File: common/bsc_pkg.sv
// constants and types for the branch, skip and compare unit
package bsc_pkg;
  localparam int PC_W = 16;
  localparam int DATA_W = 8;
  localparam int IO_ADDR_W = 6;
  localparam int REG_ADDR_W = 5;
  localparam int OFS_W = 7;
  // status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h04ff;
  localparam logic [15:0] PC_ONE = 16'h0001;
  localparam logic [15:0] PC_TWO = 16'h0002;
  localparam logic [15:0] PC_THREE = 16'h0003;
  localparam logic [15:0] SP_TWO = 16'h0002;
  localparam logic [15:0] SP_ONE = 16'h0001;
  localparam logic [3:0] NIB_MASK = 4'hf;
  // operation codes delivered by decode
  typedef enum logic [4:0] {
    BSC_OP_NONE, BSC_OP_CALL, BSC_OP_SUB_EXIT, BSC_OP_INT_EXIT,
    BSC_OP_CMP_SKIP_EQ, BSC_OP_CMP_REGS, BSC_OP_CMP_BORROW, BSC_OP_CMP_IMM,
    BSC_OP_SKIP_REG_LOW, BSC_OP_SKIP_REG_HIGH, BSC_OP_SKIP_IO_LOW, BSC_OP_SKIP_IO_HIGH,
    BSC_OP_BR_FLAG_HIGH, BSC_OP_BR_FLAG_LOW, BSC_OP_BR_EQUAL, BSC_OP_BR_UNEQUAL,
    BSC_OP_BR_CARRY_HIGH, BSC_OP_BR_CARRY_LOW, BSC_OP_BR_UNSIGNED_GE,
    BSC_OP_BR_UNSIGNED_LT, BSC_OP_BR_NEGATIVE, BSC_OP_BR_NONNEGATIVE,
    BSC_OP_BR_SIGNED_GE, BSC_OP_BR_SIGNED_LT, BSC_OP_BR_HALFCARRY_HIGH,
    BSC_OP_BR_HALFCARRY_LOW, BSC_OP_BR_TRANSFER_HIGH, BSC_OP_BR_TRANSFER_LOW,
    BSC_OP_BR_OVERFLOW_HIGH, BSC_OP_BR_OVERFLOW_LOW
  } bsc_op_t;
  typedef enum logic [2:0] {
    BSC_ST_IDLE, BSC_ST_WAIT, BSC_ST_STACK1, BSC_ST_STACK2, BSC_ST_STACK3
  } bsc_state_t;
endpackage

// File: common/bsc_cmp_if.sv
// compare operands and resulting flags between the unit and its comparator
`timescale 1ns/1ps
`default_nettype none
interface bsc_cmp_if;
  logic [7:0] lhs;
  logic [7:0] rhs;
  logic carry_in;
  logic use_carry;
  logic z_in;
  logic [7:0] flags_in;
  logic [7:0] flags_out;
  modport ctrl (output lhs, output rhs, output carry_in, output use_carry, output z_in,
    output flags_in, input flags_out);
  modport alu (input lhs, input rhs, input carry_in, input use_carry, input z_in,
    input flags_in, output flags_out);
endinterface
`default_nettype wire

// File: hw/bsc_compare.sv
// subtract-without-store comparator producing status flags
`timescale 1ns/1ps
`default_nettype none
module bsc_compare (
  bsc_cmp_if.alu cmp // operands in, flags out
);
  logic [8:0] diff;
  logic [4:0] half;
  logic [7:0] r;
  logic bin;
  always_comb begin
    bin = cmp.use_carry & cmp.carry_in;
    diff = {1'b0, cmp.lhs} - {1'b0, cmp.rhs} - {8'h00, bin};
    half = {1'b0, cmp.lhs[3:0] & bsc_pkg::NIB_MASK} - {1'b0, cmp.rhs[3:0]} - {4'h0, bin};
    r = diff[7:0];
    cmp.flags_out = cmp.flags_in;
    cmp.flags_out[bsc_pkg::FLAG_C] = diff[8];
    cmp.flags_out[bsc_pkg::FLAG_H] = half[4];
    cmp.flags_out[bsc_pkg::FLAG_N] = r[7];
    cmp.flags_out[bsc_pkg::FLAG_V] = (cmp.lhs[7] & ~cmp.rhs[7] & ~r[7]) |
      (~cmp.lhs[7] & cmp.rhs[7] & r[7]);
    cmp.flags_out[bsc_pkg::FLAG_S] = r[7] ^ cmp.flags_out[bsc_pkg::FLAG_V];
    // borrow form keeps zero only if it was already set, for multi-byte compares
    cmp.flags_out[bsc_pkg::FLAG_Z] = cmp.use_carry ? ((r == 8'h00) & cmp.z_in) : (r == 8'h00);
  end
endmodule
`default_nettype wire

// File: hw/bsc_unit.sv
// branch, skip, compare, call and return control unit of the core
// Function
// - equal-compare of two registers skips the next instruction when equal
// - a skip adds two words past one-word, three past two-word instructions
// - compares subtract register, register with carry or constant; flags only
// - register-bit-low skip skips when the chosen register bit is zero
// - register-bit-high skip skips when the chosen register bit is one
// - io-bit-low skip skips when the chosen io register bit is zero
// - io-bit-high skip skips when the chosen io register bit is one
// - flag-high branch jumps to pc plus offset plus one when indexed flag set
// - flag-low branch jumps when indexed flag is zero, else continues
// - carry-low and unsigned-same-or-higher both branch when carry is zero
// - signed greater-or-equal branches when negative xor overflow is zero
// - signed less-than branches when negative xor overflow is one
// - half-carry branches follow the half-carry flag set or clear
// - transfer branches follow the transfer flag set or clear
// - overflow branches follow the overflow flag; branches and skips keep flags
`timescale 1ns/1ps
`default_nettype none
module bsc_unit #(
  parameter int PC_WIDTH = 16 // program counter width in bits
) (
  input wire logic clk_in, // core clock
  input wire logic srst_in, // synchronous reset, active high
  input wire logic issue_in, // decode presents an instruction this cycle
  input wire bsc_pkg::bsc_op_t op_in, // decoded operation
  input wire logic [7:0] rd_val_in, // destination register value
  input wire logic [7:0] rr_val_in, // source register value
  input wire logic [7:0] imm_in, // immediate constant
  input wire logic [2:0] bit_sel_in, // bit or flag index
  input wire logic [6:0] offset_in, // signed branch offset in words
  input wire logic [PC_WIDTH-1:0] target_in, // absolute call target
  input wire logic [7:0] io_val_in, // addressed io register value
  input wire logic next_two_word_in, // following instruction is two words
  input wire logic [7:0] stack_rdata_in, // stack read data
  output logic busy_out, // unit holds decode off
  output logic [PC_WIDTH-1:0] pc_out, // program counter
  output logic [7:0] flags_out, // status_flags register
  output logic stack_we_out, // stack write strobe
  output logic stack_re_out, // stack read strobe
  output logic [15:0] stack_addr_out, // stack address
  output logic [7:0] stack_wdata_out // stack write data
);
  bsc_cmp_if cmp ();
  bsc_compare u_cmp (.cmp(cmp));

  bsc_pkg::bsc_state_t state_reg, state_next;
  logic [PC_WIDTH-1:0] pc_reg, pc_next;
  logic [7:0] flags_reg, flags_next;
  logic [15:0] sp_reg, sp_next;
  logic [1:0] wait_reg, wait_next;
  logic [PC_WIDTH-1:0] ret_reg, ret_next;
  logic [PC_WIDTH-1:0] pc_inc, pc_branch, pc_skip;
  logic cond, is_branch, is_skip, skip_cond, is_cmp;
  logic stack_we_reg, stack_re_reg;
  logic [15:0] stack_addr_reg;
  logic [7:0] stack_wdata_reg;

  assign cmp.lhs = rd_val_in;
  assign cmp.rhs = (op_in == bsc_pkg::BSC_OP_CMP_IMM) ? imm_in : rr_val_in;
  assign cmp.carry_in = flags_reg[bsc_pkg::FLAG_C];
  assign cmp.use_carry = (op_in == bsc_pkg::BSC_OP_CMP_BORROW);
  assign cmp.z_in = flags_reg[bsc_pkg::FLAG_Z];
  assign cmp.flags_in = flags_reg;

  assign pc_inc = pc_reg + PC_WIDTH'(bsc_pkg::PC_ONE);
  // offset is sign extended; pc plus offset plus one
  assign pc_branch = pc_inc + {{(PC_WIDTH-7){offset_in[6]}}, offset_in};
  assign pc_skip = pc_reg + (next_two_word_in ? PC_WIDTH'(bsc_pkg::PC_THREE)
    : PC_WIDTH'(bsc_pkg::PC_TWO));

  always_comb begin
    cond = 1'b0;
    is_branch = 1'b1;
    case (op_in)
      bsc_pkg::BSC_OP_BR_FLAG_HIGH: cond = flags_reg[bit_sel_in];
      bsc_pkg::BSC_OP_BR_FLAG_LOW: cond = ~flags_reg[bit_sel_in];
      bsc_pkg::BSC_OP_BR_EQUAL: cond = flags_reg[bsc_pkg::FLAG_Z];
      bsc_pkg::BSC_OP_BR_UNEQUAL: cond = ~flags_reg[bsc_pkg::FLAG_Z];
      bsc_pkg::BSC_OP_BR_CARRY_HIGH,
      bsc_pkg::BSC_OP_BR_UNSIGNED_LT: cond = flags_reg[bsc_pkg::FLAG_C];
      bsc_pkg::BSC_OP_BR_CARRY_LOW,
      bsc_pkg::BSC_OP_BR_UNSIGNED_GE: cond = ~flags_reg[bsc_pkg::FLAG_C];
      bsc_pkg::BSC_OP_BR_NEGATIVE: cond = flags_reg[bsc_pkg::FLAG_N];
      bsc_pkg::BSC_OP_BR_NONNEGATIVE: cond = ~flags_reg[bsc_pkg::FLAG_N];
      bsc_pkg::BSC_OP_BR_SIGNED_GE:
        cond = ~(flags_reg[bsc_pkg::FLAG_N] ^ flags_reg[bsc_pkg::FLAG_V]);
      bsc_pkg::BSC_OP_BR_SIGNED_LT:
        cond = flags_reg[bsc_pkg::FLAG_N] ^ flags_reg[bsc_pkg::FLAG_V];
      bsc_pkg::BSC_OP_BR_HALFCARRY_HIGH: cond = flags_reg[bsc_pkg::FLAG_H];
      bsc_pkg::BSC_OP_BR_HALFCARRY_LOW: cond = ~flags_reg[bsc_pkg::FLAG_H];
      bsc_pkg::BSC_OP_BR_TRANSFER_HIGH: cond = flags_reg[bsc_pkg::FLAG_T];
      bsc_pkg::BSC_OP_BR_TRANSFER_LOW: cond = ~flags_reg[bsc_pkg::FLAG_T];
      bsc_pkg::BSC_OP_BR_OVERFLOW_HIGH: cond = flags_reg[bsc_pkg::FLAG_V];
      bsc_pkg::BSC_OP_BR_OVERFLOW_LOW: cond = ~flags_reg[bsc_pkg::FLAG_V];
      default: is_branch = 1'b0;
    endcase
  end

  always_comb begin
    skip_cond = 1'b0;
    is_skip = 1'b1;
    case (op_in)
      bsc_pkg::BSC_OP_CMP_SKIP_EQ: skip_cond = (rd_val_in == rr_val_in);
      bsc_pkg::BSC_OP_SKIP_REG_LOW: skip_cond = ~rr_val_in[bit_sel_in];
      bsc_pkg::BSC_OP_SKIP_REG_HIGH: skip_cond = rr_val_in[bit_sel_in];
      bsc_pkg::BSC_OP_SKIP_IO_LOW: skip_cond = ~io_val_in[bit_sel_in];
      bsc_pkg::BSC_OP_SKIP_IO_HIGH: skip_cond = io_val_in[bit_sel_in];
      default: is_skip = 1'b0;
    endcase
  end

  assign is_cmp = (op_in == bsc_pkg::BSC_OP_CMP_REGS) || (op_in == bsc_pkg::BSC_OP_CMP_BORROW)
    || (op_in == bsc_pkg::BSC_OP_CMP_IMM);

  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    flags_next = flags_reg;
    sp_next = sp_reg;
    wait_next = wait_reg;
    ret_next = ret_reg;
    case (state_reg)
      bsc_pkg::BSC_ST_IDLE: begin
        if (issue_in) begin
          pc_next = pc_inc;
          if (is_cmp) begin
            flags_next = cmp.flags_out;
          end else if (is_branch && cond) begin
            // taken branch spends one extra cycle refilling fetch
            pc_next = pc_branch;
            wait_next = 2'd1;
            state_next = bsc_pkg::BSC_ST_WAIT;
          end else if (is_skip && skip_cond) begin
            pc_next = pc_skip;
            wait_next = next_two_word_in ? 2'd2 : 2'd1;
            state_next = bsc_pkg::BSC_ST_WAIT;
          end else if (op_in == bsc_pkg::BSC_OP_CALL) begin
            ret_next = PC_WIDTH'(pc_reg + PC_WIDTH'(bsc_pkg::PC_TWO)); // two-word call
            pc_next = pc_reg;
            state_next = bsc_pkg::BSC_ST_STACK1;
          end else if (op_in == bsc_pkg::BSC_OP_SUB_EXIT
              || op_in == bsc_pkg::BSC_OP_INT_EXIT) begin
            pc_next = pc_reg;
            if (op_in == bsc_pkg::BSC_OP_INT_EXIT) begin
              flags_next[bsc_pkg::FLAG_I] = 1'b1;
            end
            ret_next = '0;
            state_next = bsc_pkg::BSC_ST_STACK1;
          end
        end
      end
      bsc_pkg::BSC_ST_WAIT: begin
        wait_next = wait_reg - 2'd1;
        if (wait_reg == 2'd1) begin
          state_next = bsc_pkg::BSC_ST_IDLE;
        end
      end
      bsc_pkg::BSC_ST_STACK1: begin
        state_next = bsc_pkg::BSC_ST_STACK2;
      end
      bsc_pkg::BSC_ST_STACK2: begin
        state_next = bsc_pkg::BSC_ST_STACK3;
      end
      bsc_pkg::BSC_ST_STACK3: begin
        state_next = bsc_pkg::BSC_ST_IDLE;
      end
      default: state_next = bsc_pkg::BSC_ST_IDLE;
    endcase
  end

  // stack side effects: push low then high on call, pop high then low on return
  logic is_push_reg;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      is_push_reg <= 1'b0;
    end else if (state_reg == bsc_pkg::BSC_ST_IDLE && issue_in) begin
      is_push_reg <= (op_in == bsc_pkg::BSC_OP_CALL);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      stack_we_reg <= 1'b0;
      stack_re_reg <= 1'b0;
      stack_addr_reg <= 16'h0000;
      stack_wdata_reg <= 8'h00;
      sp_reg <= bsc_pkg::SP_RESET;
    end else begin
      stack_we_reg <= 1'b0;
      stack_re_reg <= 1'b0;
      if (state_next == bsc_pkg::BSC_ST_STACK1 || state_next == bsc_pkg::BSC_ST_STACK2) begin
        if (state_next == bsc_pkg::BSC_ST_STACK1 ? (op_in == bsc_pkg::BSC_OP_CALL)
            : is_push_reg) begin
          stack_we_reg <= 1'b1;
          stack_addr_reg <= sp_reg;
          sp_reg <= sp_reg - bsc_pkg::SP_ONE;
          stack_wdata_reg <= (state_next == bsc_pkg::BSC_ST_STACK1)
            ? 8'(ret_next) : 8'(ret_reg >> 8);
        end else begin
          stack_re_reg <= 1'b1;
          stack_addr_reg <= sp_reg + bsc_pkg::SP_ONE;
          sp_reg <= sp_reg + bsc_pkg::SP_ONE;
        end
      end
    end
  end

  // popped bytes land one cycle after each read strobe
  logic [7:0] pop_hi_reg;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pop_hi_reg <= 8'h00;
    end else if (state_reg == bsc_pkg::BSC_ST_STACK2 && !is_push_reg) begin
      pop_hi_reg <= stack_rdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= bsc_pkg::BSC_ST_IDLE;
      pc_reg <= PC_WIDTH'(bsc_pkg::PC_RESET);
      flags_reg <= bsc_pkg::FLAGS_RESET;
      wait_reg <= 2'd0;
      ret_reg <= '0;
    end else begin
      state_reg <= state_next;
      flags_reg <= flags_next;
      wait_reg <= wait_next;
      ret_reg <= ret_next;
      if (state_reg == bsc_pkg::BSC_ST_STACK3) begin
        pc_reg <= is_push_reg ? target_in
          : PC_WIDTH'({pop_hi_reg, stack_rdata_in});
      end else begin
        pc_reg <= pc_next;
      end
    end
  end

  assign busy_out = (state_reg != bsc_pkg::BSC_ST_IDLE);
  assign pc_out = pc_reg;
  assign flags_out = flags_reg;
  assign stack_we_out = stack_we_reg;
  assign stack_re_out = stack_re_reg;
  assign stack_addr_out = stack_addr_reg;
  assign stack_wdata_out = stack_wdata_reg;
endmodule
`default_nettype wire

// File: tb/bsc_unit_chk.sv
// port-level assertions for the branch, skip and compare unit
`timescale 1ns/1ps
`default_nettype none
module bsc_unit_chk #(
  parameter int PC_WIDTH = 16 // program counter width
) (
  input wire logic clk_in, // clock
  input wire logic srst_in, // reset
  input wire logic issue_in, // issue
  input wire bsc_pkg::bsc_op_t op_in, // operation
  input wire logic [7:0] rd_val_in, // rd
  input wire logic [7:0] rr_val_in, // rr
  input wire logic [7:0] imm_in, // immediate
  input wire logic [2:0] bit_sel_in, // bit index
  input wire logic [6:0] offset_in, // offset
  input wire logic [PC_WIDTH-1:0] target_in, // call target
  input wire logic [7:0] io_val_in, // io value
  input wire logic next_two_word_in, // two-word next
  input wire logic busy_out, // busy
  input wire logic [PC_WIDTH-1:0] pc_out, // pc
  input wire logic [7:0] flags_out, // flags
  input wire logic stack_we_out, // stack write
  input wire logic [15:0] stack_addr_out, // stack address
  input wire logic [7:0] stack_wdata_out // stack data
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  logic go;
  logic [PC_WIDTH-1:0] ofs_ext;
  assign go = issue_in && !busy_out;
  assign ofs_ext = {{(PC_WIDTH-7){offset_in[6]}}, offset_in};
  AST_CMP_IMM: assert property (go && op_in == bsc_pkg::BSC_OP_CMP_IMM |=>
    !busy_out && flags_out[0] == ($past(rd_val_in) < $past(imm_in)))
    else $error("compare immediate carry or timing wrong");
  AST_BR_EQ_TAKEN: assert property (go && op_in == bsc_pkg::BSC_OP_BR_EQUAL && flags_out[1]
    |=> busy_out && pc_out == PC_WIDTH'($past(pc_out) + $past(ofs_ext) + 1'b1) ##1 !busy_out)
    else $error("taken branch target or length wrong");
  AST_BR_NE_UNTAKEN: assert property (go && op_in == bsc_pkg::BSC_OP_BR_UNEQUAL && flags_out[1]
    |=> !busy_out && pc_out == PC_WIDTH'($past(pc_out) + 1'b1))
    else $error("untaken branch did not fall through");
  AST_BR_KEEP_FLAGS: assert property (go && op_in >= bsc_pkg::BSC_OP_BR_FLAG_HIGH
    |=> $stable(flags_out))
    else $error("branch altered flags");
  AST_FLAG_LOW: assert property (go && op_in == bsc_pkg::BSC_OP_BR_FLAG_LOW
    && flags_out[bit_sel_in] |=> pc_out == PC_WIDTH'($past(pc_out) + 1'b1))
    else $error("flag-low branch taken on set flag");
  AST_SKIP_EQ_TWO: assert property (go && op_in == bsc_pkg::BSC_OP_CMP_SKIP_EQ
    && rd_val_in == rr_val_in && next_two_word_in
    |=> busy_out && pc_out == PC_WIDTH'($past(pc_out) + 2'd3) ##1 busy_out ##1 !busy_out)
    else $error("two-word skip wrong");
  AST_SKIP_IO_HIGH: assert property (go && op_in == bsc_pkg::BSC_OP_SKIP_IO_HIGH
    && io_val_in[bit_sel_in] && !next_two_word_in
    |=> busy_out && pc_out == PC_WIDTH'($past(pc_out) + 2'd2) ##1 !busy_out)
    else $error("io bit skip wrong");
  AST_LONG_BUSY: assert property (go && op_in inside {bsc_pkg::BSC_OP_CALL,
    bsc_pkg::BSC_OP_SUB_EXIT, bsc_pkg::BSC_OP_INT_EXIT} |=> busy_out [*3] ##1 !busy_out)
    else $error("call or return not four cycles");
  AST_CALL_PUSH: assert property (go && op_in == bsc_pkg::BSC_OP_CALL
    |=> stack_we_out && stack_wdata_out == 8'($past(pc_out) + 2'd2) ##1 stack_we_out
    && stack_addr_out == $past(stack_addr_out) - 1'b1 ##2 pc_out == $past(target_in, 4))
    else $error("call push or target wrong");
  AST_INT_EXIT_I: assert property (go && op_in == bsc_pkg::BSC_OP_INT_EXIT |=> flags_out[7])
    else $error("interrupt exit left enable clear");
  COV_TAKEN: cover property (go && op_in == bsc_pkg::BSC_OP_BR_EQUAL && flags_out[1]);
  COV_CALL: cover property (go && op_in == bsc_pkg::BSC_OP_CALL);
  COV_SKIP2: cover property (go && op_in == bsc_pkg::BSC_OP_CMP_SKIP_EQ && next_two_word_in);
endmodule
`default_nettype wire

// File: tb/bsc_unit_tb_top.sv
// self-checking bench for the branch, skip and compare unit
`timescale 1ns/1ps
`default_nettype none
module bsc_unit_tb_top;
  logic clk_in = 1'b0;
  logic srst_in, issue_in, next_two_word_in, busy_out, stack_we_out, stack_re_out;
  bsc_pkg::bsc_op_t op_in;
  logic [7:0] rd_val_in, rr_val_in, imm_in, io_val_in, stack_rdata_in, flags_out;
  logic [7:0] stack_wdata_out, exp_flags;
  logic [2:0] bit_sel_in;
  logic [6:0] offset_in;
  logic [15:0] target_in, pc_out, stack_addr_out, exp_pc;
  logic [7:0] mem [0:65535];
  logic [15:0] stk [$];
  int seed = 14405;
  int mismatches = 0;
  int num_checks = 0;
  always #10 clk_in = ~clk_in;
  bsc_unit u_bsc_unit (.clk_in, .srst_in, .issue_in, .op_in, .rd_val_in, .rr_val_in, .imm_in,
    .bit_sel_in, .offset_in, .target_in, .io_val_in, .next_two_word_in, .stack_rdata_in,
    .busy_out, .pc_out, .flags_out, .stack_we_out, .stack_re_out, .stack_addr_out,
    .stack_wdata_out);
  // stack memory; between reads the data line toggles so stale data never matches
  always @(posedge clk_in) begin
    if (stack_we_out)
      mem[stack_addr_out] <= stack_wdata_out;
    stack_rdata_in <= stack_re_out ? mem[stack_addr_out] : ~stack_rdata_in;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] cmpf(logic [7:0] a, logic [7:0] b, logic c, logic zk,
    logic [7:0] f);
    logic [7:0] r;
    r = a - b - 8'(c);
    f[0] = (!a[7] & b[7]) | (b[7] & r[7]) | (r[7] & !a[7]);
    f[5] = (!a[3] & b[3]) | (b[3] & r[3]) | (r[3] & !a[3]);
    f[3] = (a[7] & !b[7] & !r[7]) | (!a[7] & b[7] & r[7]);
    f[2] = r[7];
    f[1] = (r == 8'h00) && (!zk || f[1]);
    return f;
  endfunction
  function automatic logic brc(int o, logic [7:0] f, logic [2:0] s);
    logic b;
    if (o < 14)
      return (o == 12) ? f[s] : !f[s];
    case (o)
      14, 15: b = f[1];
      16, 17, 18, 19: b = f[0];
      20, 21: b = f[2];
      22, 23: b = f[2] ^ f[3];
      24, 25: b = f[5];
      26, 27: b = f[6];
      default: b = f[3];
    endcase
    return ((o % 2 == 0) ^ (o inside {18, 19, 22, 23})) ? b : !b;
  endfunction
  task automatic run(input int o, input logic [7:0] a, input logic [7:0] b,
    input logic [2:0] s, input logic two, input logic [6:0] k);
    logic [15:0] tgt, ep;
    logic [7:0] ef;
    int cyc, n;
    tgt = 16'($random(seed));
    ep = exp_pc + 16'h0001;
    ef = exp_flags;
    cyc = 1;
    if (o == 8 || o == 9)
      b = a;
    if (o == 1) begin
      stk.push_back(exp_pc + 16'h0002);
      ep = tgt;
      cyc = 4;
    end else if (o == 2 || o == 3) begin
      ep = stk.pop_back();
      ef[7] = ef[7] | (o == 3);
      cyc = 4;
    end else if (o >= 5 && o <= 7) begin
      ef = cmpf(a, b, o == 6 && ef[0], o == 6, ef);
    end else if (o >= 12 && o <= 29 && brc(o, ef, s)) begin
      ep = exp_pc + {{9{k[6]}}, k} + 16'h0001;
      cyc = 2;
    end else if ((o == 4 && a == b) || ((o == 8 || o == 10) && !a[s]) ||
      ((o == 9 || o == 11) && a[s])) begin
      ep = exp_pc + (two ? 16'h0003 : 16'h0002);
      cyc = two ? 3 : 2;
    end
    @(posedge clk_in);
    issue_in <= 1'b1;
    op_in <= bsc_pkg::bsc_op_t'(o);
    {rd_val_in, rr_val_in, imm_in, io_val_in} <= {a, b, b, a};
    {bit_sel_in, next_two_word_in, offset_in, target_in} <= {s, two, k, tgt};
    @(posedge clk_in);
    issue_in <= 1'b0;
    #1;
    n = 1;
    while (busy_out === 1'b1 && n < 8) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check(16'(n), 16'(cyc));
    check(pc_out, ep);
    check({8'h00, flags_out} & 16'h00ef, {8'h00, ef} & 16'h00ef);
    exp_pc = ep;
    exp_flags = ef;
  endtask
  initial begin
    int o;
    logic [7:0] a, b;
    {srst_in, issue_in, next_two_word_in, stack_rdata_in} = {1'b1, 1'b0, 1'b0, 8'h00};
    {rd_val_in, rr_val_in, imm_in, io_val_in, bit_sel_in, offset_in, target_in} = '0;
    op_in = bsc_pkg::BSC_OP_NONE;
    {exp_pc, exp_flags} = '0;
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    check({pc_out[7:0], flags_out}, 16'h0000);
    run(7, 8'h80, 8'h01, 3'h0, 1'b0, 7'h00);
    run(23, 8'h00, 8'h00, 3'h0, 1'b0, 7'h40);
    run(4, 8'h5a, 8'h5a, 3'h0, 1'b1, 7'h00);
    run(11, 8'h80, 8'h00, 3'h7, 1'b0, 7'h00);
    run(1, 8'h00, 8'h00, 3'h0, 1'b0, 7'h00);
    run(1, 8'h00, 8'h00, 3'h0, 1'b0, 7'h00);
    run(3, 8'h00, 8'h00, 3'h0, 1'b0, 7'h00);
    run(2, 8'h00, 8'h00, 3'h0, 1'b0, 7'h00);
    $display("corner test done");
    repeat (400) begin
      o = int'($unsigned($random(seed)) % 30);
      if (o == 1 && stk.size() > 3)
        o = 5;
      if ((o == 2 || o == 3) && stk.size() == 0)
        o = 1;
      a = 8'($random(seed));
      b = (($random(seed) & 3) == 0) ? a : 8'($random(seed));
      run(o, a, b, 3'($random(seed)), 1'($random(seed)), 7'($random(seed)));
    end
    $display("random test done");
    give_verdict();
  end
  initial begin
    #2000000;
    mismatches++;
    give_verdict();
  end
endmodule
bind bsc_unit bsc_unit_chk #(.PC_WIDTH(PC_WIDTH)) u_bsc_unit_chk (.clk_in, .srst_in, .issue_in,
  .op_in, .rd_val_in, .rr_val_in, .imm_in, .bit_sel_in, .offset_in, .target_in, .io_val_in,
  .next_two_word_in, .busy_out, .pc_out, .flags_out, .stack_we_out, .stack_addr_out,
  .stack_wdata_out);
`default_nettype wire
